// *** hdl/ssap_alarm.sv ***
// one thermal comparator with hysteresis on release
`timescale 1ns/1ns
`default_nettype none
module ssap_alarm (
  input  wire logic       pclk,    // system clock
  input  wire logic       presetn, // async reset, active low
  input  wire logic       clr,     // synchronous clear
  input  wire logic       update,  // new conversion result
  input  wire logic [7:0] temp,    // measured temperature
  input  wire logic [7:0] hi,      // upper limit
  input  wire logic [7:0] lo,      // lower limit
  input  wire logic       use_lo,  // lower limit in use
  input  wire logic [7:0] hyst,    // release hysteresis
  output logic            alarm    // alarm level
);
  logic trip;
  logic back_in;

  assign trip    = (temp >= hi) || (use_lo && (temp < lo));
  assign back_in = ({1'b0, temp} + {1'b0, hyst} < {1'b0, hi}) &&
                   (!use_lo || ({1'b0, temp} >= {1'b0, lo} + {1'b0, hyst}));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= 1'b0;
    end else if (clr) begin
      alarm <= 1'b0;
    end else if (update) begin
      alarm <= trip || (alarm && !back_in);
    end
  end
endmodule
`default_nettype wire

// *** hdl/ssap_pkg.sv ***
// shared constants and types for the smbus slave with alarm pins
package ssap_pkg;

  // ****************************************
  // bus addresses and codes
  // ****************************************
  localparam logic [6:0] OWN_ADDR    = 7'h4c;
  localparam logic [7:0] GC_ADDR     = 8'h00;
  localparam logic [7:0] GC_RESET    = 8'h06;
  localparam logic [7:0] ARA_BYTE    = 8'h19;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  // ****************************************
  // apb register offsets
  // ****************************************
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_CONS   = 8'h04;
  localparam logic [7:0] REG_HYST   = 8'h08;
  localparam logic [7:0] REG_LTHERM = 8'h0c;
  localparam logic [7:0] REG_RTHERM = 8'h10;
  localparam logic [7:0] REG_LHI    = 8'h14;
  localparam logic [7:0] REG_LLO    = 8'h18;
  localparam logic [7:0] REG_RHI    = 8'h1c;
  localparam logic [7:0] REG_RLO    = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_STATE  = 8'h28;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_SEL_BIT  = 5;
  localparam int CONS_TO_BIT  = 7;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] CONS_RST   = 8'h80;
  localparam logic [7:0] HYST_RST   = 8'h0a;
  localparam logic [7:0] OVER_TEMP_ALARM_PIN_RST  = 8'h55;
  localparam logic [7:0] HI_RST     = 8'h55;
  localparam logic [7:0] LO_RST     = 8'h00;
  localparam logic [2:0] CONS_1     = 3'h0;
  localparam logic [2:0] CONS_2     = 3'h1;
  localparam logic [2:0] CONS_3     = 3'h3;
  localparam logic [2:0] CONS_4     = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int TIMEOUT_MS  = 30;
  localparam int CLK_KHZ     = 100000;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RECV = 7'h02,
    ST_ACKW = 7'h04,
    ST_ACK  = 7'h08,
    ST_SEND = 7'h10,
    ST_MACK = 7'h20,
    ST_SKIP = 7'h40
  } ssap_state_e;

endpackage

// *** hdl/ssap_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ssap_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous inputs
  output logic      [W-1:0] q        // synchronised outputs
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_chk
    $error("ssap_sync width must be at least one");
  end

  // idle bus level is high, so reset to ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** hdl/ssap_top.sv ***
// smbus slave interface with alarm pin logic and apb registers
// Function
// - first byte after a write address loads the pointer
// - reads use the last written pointer, kept until rewritten
// - a pointer-only write is accepted, then repeated start and read
// - two-byte registers go out high byte first, msb first
// - start and stop are sda edges while scl is high
// - the receiver pulls sda low through the acknowledge clock
// - master nack on a read byte makes the device release sda
// - no limit on the number of bytes in a transfer
// - hs master code is not acknowledged but enables hs filters
// - hs mode holds over repeated starts, ends at stop
// - timeout enable is bit 7 of consecutive register, reset one
// - line low 30 ms inside a transfer resets the interface
// - over-temperature pin follows over_temp_alarm_pin limits, cannot be masked
// - over-temperature pin releases below limit minus hysteresis
// - select set, mask clear: second pin is a thermal alarm
// - alert needs one to four consecutive violating conversions
// - alert also asserts on remote sensor open circuit
// - mask bit set holds the alert inactive
// - alert clears on own address read once cause and status clear
// - device answers address 1001100 plus direction bit, general call, and alert response while alert is active
// - consecutive count encodes one to four, default one
// - alert response returns own address, lsb marks high cause
// - general call acked, second byte 06h resets registers and pins
`timescale 1ns/1ns
`default_nettype none
module ssap_top
  import ssap_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        pclk,          // system clock, 100 mhz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped
  input  wire logic        scl_in,        // bus clock pin
  input  wire logic        sda_in,        // bus data pin level
  output logic             sda_out,       // bus data drive value
  output logic             sda_oe_n,      // bus data drive, active low
  output logic      [7:0]  ptr,           // register pointer
  input  wire logic [15:0] reg_rdata,     // register selected by ptr
  output logic             wr_strobe,     // write data byte pulse
  output logic      [7:0]  wr_data,       // write data byte
  output logic             hs_mode,       // high-speed filter select
  input  wire logic        conv_done,     // conversion result pulse
  input  wire logic [7:0]  local_temp,    // local temperature
  input  wire logic [7:0]  remote_temp,   // remote temperature
  input  wire logic        remote_open,   // remote sensor open circuit
  output logic             over_temp_alarm_pin_out,  // drive value
  output logic             over_temp_alarm_pin_oe_n, // drive, low
  output logic             second_thermal_alarm_out, // drive value
  output logic             second_thermal_alarm_oe_n // drive, low
);
  // ****************************************
  // line sampling and bus conditions
  // ****************************************
  logic       scl_s, sda_s, scl_d, sda_d;
  logic [1:0] sync_q;

  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << 22)) begin : g_chk
    $error("ssap_top timeout count out of range");
  end

  ssap_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({scl_in, sda_in}),
    .q       (sync_q)
  );
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] cfg, cons, hyst, ltherm, rtherm, lhi, llo, rhi, rlo;
  logic [4:0] status;
  logic       soft_rst, alert_act, high_cause, busy;
  logic       mask, sel, to_en;
  logic [3:0] alm;

  assign mask  = cfg[CFG_MASK_BIT];
  assign sel   = cfg[CFG_SEL_BIT];
  assign to_en = cons[CONS_TO_BIT];

  // ****************************************
  // serial engine
  // ****************************************
  ssap_state_e state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg, txsh;
  logic        is_addr, rd, first_data, gc, ara, txsel, pull;
  logic        rd_own, ara_done;
  logic [21:0] to_cnt;

  logic [7:0] byte_in, tx_next;
  logic       byte_done, addr_me, addr_gc, addr_ara, addr_hs, ack_ok;
  logic       to_run, to_hit;

  assign byte_in   = {shreg[6:0], sda_s};
  assign byte_done = (state == ST_RECV) && scl_rise && (bitcnt == 4'h7);
  assign addr_me   = byte_in[7:1] == OWN_ADDR;
  assign addr_gc   = byte_in == GC_ADDR;
  assign addr_ara  = (byte_in == ARA_BYTE) && alert_act;
  assign addr_hs   = byte_in[7:3] == HS_CODE_TOP;
  assign ack_ok    = addr_me || addr_gc || addr_ara;
  assign tx_next   = ara ? {OWN_ADDR, high_cause} :
                     (txsel ? reg_rdata[7:0] : reg_rdata[15:8]);
  assign to_run    = busy && to_en && (!scl_s || !sda_s);
  assign to_hit    = to_run && (to_cnt == 22'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= to_run ? to_cnt + 22'h1 : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE; bitcnt <= '0; shreg <= '0; txsh <= '0;
      is_addr <= 1'b0; rd <= 1'b0; first_data <= 1'b0; gc <= 1'b0;
      ara <= 1'b0; txsel <= 1'b0; pull <= 1'b0; ptr <= '0;
      wr_strobe <= 1'b0; wr_data <= '0; hs_mode <= 1'b0; busy <= 1'b0;
      rd_own <= 1'b0; ara_done <= 1'b0; soft_rst <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      rd_own    <= 1'b0;
      ara_done  <= 1'b0;
      soft_rst  <= 1'b0;
      if (stop_det) begin
        state <= ST_IDLE; pull <= 1'b0; busy <= 1'b0;
        hs_mode <= 1'b0;
      end else if (start_det) begin
        // repeated start keeps hs mode
        state <= ST_RECV; bitcnt <= '0; is_addr <= 1'b1;
        pull <= 1'b0; busy <= 1'b1;
      end else if (to_hit) begin
        state <= ST_IDLE; pull <= 1'b0; busy <= 1'b0;
      end else begin
        case (state)
          ST_RECV: begin
            if (scl_rise) begin
              shreg  <= byte_in;
              bitcnt <= bitcnt + 4'h1;
            end
            if (byte_done && is_addr) begin
              is_addr <= 1'b0; first_data <= 1'b1; txsel <= 1'b0;
              rd <= byte_in[0]; gc <= addr_gc && !byte_in[0];
              ara <= addr_ara;
              rd_own <= addr_me && byte_in[0];
              if (addr_hs) begin
                hs_mode <= 1'b1; state <= ST_SKIP;
              end else if (ack_ok) begin
                state <= ST_ACKW;
              end else begin
                state <= ST_SKIP;
              end
            end else if (byte_done) begin
              first_data <= 1'b0;
              state      <= ST_ACKW;
              if (gc) begin
                soft_rst <= byte_in == GC_RESET;
              end else if (first_data) begin
                ptr <= byte_in;
              end else begin
                wr_strobe <= 1'b1; wr_data <= byte_in;
              end
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              pull <= 1'b1; state <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= '0;
              if (rd) begin
                txsh  <= tx_next;
                pull  <= !tx_next[7];
                txsel <= !txsel;
                state <= ST_SEND;
              end else begin
                pull  <= 1'b0; state <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_rise && !pull && !sda_s) begin
              state <= ST_SKIP; // lost arbitration
            end else if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              pull <= 1'b0; state <= ST_MACK;
            end else if (scl_fall) begin
              txsh <= {txsh[6:0], 1'b0};
              pull <= !txsh[6];
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ara_done <= ara;
              ara      <= 1'b0;
              state    <= sda_s ? ST_SKIP : ST_ACK;
            end
          end
          ST_IDLE, ST_SKIP: begin
            pull <= 1'b0;
          end
          default: begin
            state <= ST_IDLE; pull <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = !pull;

  // ****************************************
  // limit checks and alert filter
  // ****************************************
  logic [1:0] viol, viol_hi, cur_viol, filt_met;
  logic [1:0] cnt [2];
  logic [1:0] need_m1;

  assign viol_hi[0] = local_temp >= lhi;
  assign viol_hi[1] = remote_temp >= rhi;
  assign viol[0]    = viol_hi[0] || (local_temp < llo);
  assign viol[1]    = viol_hi[1] || (remote_temp < rlo);
  assign need_m1    = (cons[2:0] == CONS_4) ? 2'h3 :
                      (cons[2:0] == CONS_3) ? 2'h2 :
                      (cons[2:0] == CONS_2) ? 2'h1 : 2'h0;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign filt_met[c] = viol[c] && (cnt[c] >= need_m1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[c] <= '0;
      end else if (soft_rst) begin
        cnt[c] <= '0;
      end else if (conv_done) begin
        cnt[c] <= !viol[c] ? 2'h0 : (cnt[c] == 2'h3 ? 2'h3 : cnt[c] + 2'h1);
      end
    end
  end

  logic alert_set, alert_clr;
  assign alert_set = (conv_done && (|filt_met)) || remote_open;
  assign alert_clr = (rd_own && !(|cur_viol) && !remote_open &&
                      status == 5'h0) || ara_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_act  <= 1'b0;
      high_cause <= 1'b0;
      cur_viol   <= '0;
    end else if (soft_rst) begin
      alert_act  <= 1'b0; high_cause <= 1'b0; cur_viol <= '0;
    end else begin
      if (conv_done) begin
        cur_viol <= viol;
      end
      if (alert_set) begin
        alert_act  <= 1'b1; // set wins over clear
        high_cause <= |(viol_hi & filt_met & {2{conv_done}});
      end else if (alert_clr) begin
        alert_act  <= 1'b0;
      end
    end
  end

  // ****************************************
  // thermal alarms and pin drivers
  // ****************************************
  logic [7:0] a_temp [4];
  logic [7:0] a_hi   [4];
  logic [7:0] a_lo   [4];
  assign a_temp = '{local_temp, remote_temp, local_temp, remote_temp};
  assign a_hi   = '{ltherm, rtherm, lhi, rhi};
  assign a_lo   = '{8'h00, 8'h00, llo, rlo};

  for (genvar i = 0; i < 4; i++) begin : g_alm
    ssap_alarm u_alm (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (soft_rst),
      .update  (conv_done),
      .temp    (a_temp[i]),
      .hi      (a_hi[i]),
      .lo      (a_lo[i]),
      .use_lo  (i >= 2),
      .hyst    (hyst),
      .alarm   (alm[i])
    );
  end

  logic next_second;
  assign next_second = !mask && (sel ? (|alm[3:2]) : alert_act);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_temp_alarm_pin_oe_n  <= 1'b1;
      second_thermal_alarm_oe_n <= 1'b1;
    end else begin
      over_temp_alarm_pin_oe_n  <= !(|alm[1:0]);
      second_thermal_alarm_oe_n <= !next_second;
    end
  end
  assign over_temp_alarm_pin_out  = 1'b0;
  assign second_thermal_alarm_out = 1'b0;

  // ****************************************
  // apb slave
  // ****************************************
  logic        wr_en, rd_setup, hit;
  logic [31:0] rd_mux;
  logic [4:0]  st_set;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit      = paddr <= REG_STATE && paddr[1:0] == 2'b00;
  assign st_set   = conv_done ? {remote_open, viol[1] && !viol_hi[1],
                    viol_hi[1], viol[0] && !viol_hi[0], viol_hi[0]} :
                    {remote_open, 4'h0};
  assign rd_mux =
    (paddr == REG_CFG)    ? {24'h0, cfg}    :
    (paddr == REG_CONS)   ? {24'h0, cons}   :
    (paddr == REG_HYST)   ? {24'h0, hyst}   :
    (paddr == REG_LTHERM) ? {24'h0, ltherm} :
    (paddr == REG_RTHERM) ? {24'h0, rtherm} :
    (paddr == REG_LHI)    ? {24'h0, lhi}    :
    (paddr == REG_LLO)    ? {24'h0, llo}    :
    (paddr == REG_RHI)    ? {24'h0, rhi}    :
    (paddr == REG_RLO)    ? {24'h0, rlo}    :
    (paddr == REG_STATUS) ? {27'h0, status} :
    (paddr == REG_STATE)  ? {19'h0, !second_thermal_alarm_oe_n,
                             !over_temp_alarm_pin_oe_n, alert_act,
                             busy, hs_mode, ptr} : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RST; cons <= CONS_RST; hyst <= HYST_RST;
      ltherm <= OVER_TEMP_ALARM_PIN_RST; rtherm <= OVER_TEMP_ALARM_PIN_RST;
      lhi <= HI_RST; rhi <= HI_RST; llo <= LO_RST; rlo <= LO_RST;
    end else if (soft_rst) begin
      cfg <= CFG_RST; cons <= CONS_RST; hyst <= HYST_RST;
      ltherm <= OVER_TEMP_ALARM_PIN_RST; rtherm <= OVER_TEMP_ALARM_PIN_RST;
      lhi <= HI_RST; rhi <= HI_RST; llo <= LO_RST; rlo <= LO_RST;
    end else if (wr_en) begin
      if (paddr == REG_CFG)    cfg    <= pwdata[7:0];
      if (paddr == REG_CONS)   cons   <= pwdata[7:0];
      if (paddr == REG_HYST)   hyst   <= pwdata[7:0];
      if (paddr == REG_LTHERM) ltherm <= pwdata[7:0];
      if (paddr == REG_RTHERM) rtherm <= pwdata[7:0];
      if (paddr == REG_LHI)    lhi    <= pwdata[7:0];
      if (paddr == REG_LLO)    llo    <= pwdata[7:0];
      if (paddr == REG_RHI)    rhi    <= pwdata[7:0];
      if (paddr == REG_RLO)    rlo    <= pwdata[7:0];
    end
  end

  // status bits: write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (soft_rst) begin
      status <= '0;
    end else begin
      status <= st_set | (status &
                ~((wr_en && paddr == REG_STATUS) ? pwdata[4:0] : 5'h0));
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ack_pull_low: assert property (
    (state == ST_ACKW && scl_fall && !stop_det && !start_det && !to_hit)
    |=> !sda_oe_n && state == ST_ACK)
    else $error("ack not driven low");
  a_hs_no_ack: assert property (
    (byte_done && is_addr && addr_hs && !to_hit)
    |=> hs_mode && state == ST_SKIP && sda_oe_n)
    else $error("hs master code mishandled");
  a_hs_stop_clear: assert property (
    stop_det |=> !hs_mode)
    else $error("hs mode kept after stop");
  a_ptr_hold_read: assert property (
    (state == ST_SEND) |-> $stable(ptr))
    else $error("pointer changed during read");
  a_timeout_reset: assert property (
    (to_hit && !start_det && !stop_det) |=> state == ST_IDLE && sda_oe_n)
    else $error("timeout did not reset interface");
  a_nack_release: assert property (
    (state == ST_MACK && scl_rise && sda_s && !start_det && !stop_det
     && !to_hit) |=> state == ST_SKIP ##1 sda_oe_n)
    else $error("device kept driving after nack");
  a_foreign_ignore: assert property (
    (byte_done && is_addr && !ack_ok && !to_hit)
    |=> state == ST_SKIP && sda_oe_n)
    else $error("foreign address not ignored");
  a_alert_masked: assert property (
    (mask && $past(mask)) |-> second_thermal_alarm_oe_n)
    else $error("masked alert drove pin");
  a_over_temp_alarm_pin_follows: assert property (
    (|alm[1:0]) |=> !over_temp_alarm_pin_oe_n)
    else $error("over temperature pin not asserted");
  a_gc_reset_regs: assert property (
    soft_rst |=> cfg == CFG_RST && cons == CONS_RST && !alert_act)
    else $error("general call reset incomplete");
endmodule
`default_nettype wire

// *** testbench/ssap_master.sv ***
// two-wire bus master model for the slave bench
`timescale 1ns/1ns
`default_nettype none
module ssap_master (
  input  wire logic sda_w, // resolved sda level
  output logic      scl,   // bus clock, stands high when idle
  output logic      sda    // high releases, low pulls
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // 125 ns bit: data moves in low phase, sampled in high phase
  task automatic bit_io(input logic b, output logic r);
    #31 sda <= b;
    #31 scl <= 1'b1;
    #31 r = sda_w;
    #32 scl <= 1'b0;
  endtask
  task automatic start();
    #31 sda <= 1'b1;
    #31 scl <= 1'b1;
    #31 sda <= 1'b0;
    #32 scl <= 1'b0;
  endtask
  task automatic stop();
    #31 sda <= 1'b0;
    #31 scl <= 1'b1;
    #31 sda <= 1'b1;
    #32;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, ak);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_smbus_slave_with_alarm_pins.sv ***
// self-checking bench for the smbus slave with alarm pins
`timescale 1ns/1ns
`default_nettype none
module tb_smbus_slave_with_alarm_pins;
  import ssap_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, q, lt = 0, rt = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, sda_out, sda_oe_n, wr_strobe, hs_mode, e, ak;
  logic [7:0] ptr, wr_data;
  logic cd = 0, ro = 0, ot_o, ot_n, st_o, st_n, scl, m_sda, sda_w;
  int err_count = 0, n_tests = 0, n_wr = 0;
  assign sda_w = m_sda & (sda_oe_n | sda_out);
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (wr_strobe === 1'b1) n_wr++;
  ssap_top #(.TIMEOUT_CYCLES(400)) ssap_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .ptr(ptr), .reg_rdata(16'ha55a),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .hs_mode(hs_mode),
    .conv_done(cd), .local_temp(lt), .remote_temp(rt), .remote_open(ro),
    .over_temp_alarm_pin_out(ot_o), .over_temp_alarm_pin_oe_n(ot_n),
    .second_thermal_alarm_out(st_o), .second_thermal_alarm_oe_n(st_n));
  ssap_master ssap_master_i (.sda_w(sda_w), .scl(scl), .sda(m_sda));
  task automatic chk(input string n, input logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic conv(input logic [7:0] l, r);
    @(posedge pclk);
    cd <= 1; lt <= l; rt <= r;
    @(posedge pclk);
    cd <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(0, REG_CONS, 0); chk("cons", rd, 32'h80);
    apb(0, REG_HYST, 0); chk("hyst", rd, 32'h0a);
    apb(0, REG_CFG, 0); chk("cfg", rd, 32'h00);
    apb(0, 8'h2c, 0); chk("unmapped", e, 1);
    chk("open drain", {sda_out, ot_o, st_o}, 0);
    $display("test regs done");
  endtask
  task automatic t_bus();
    ssap_master_i.start();
    ssap_master_i.xfer(8'h98, 1, q, ak); chk("addr ack", ak, 0);
    ssap_master_i.xfer(8'h05, 1, q, ak); chk("ptr ack", ak, 0);
    chk("ptr", ptr, 8'h05);
    ssap_master_i.xfer(8'h3c, 1, q, ak); chk("data", wr_data, 8'h3c);
    ssap_master_i.xfer(8'hc3, 1, q, ak); chk("data2", wr_data, 8'hc3);
    chk("strobes", n_wr, 2);
    ssap_master_i.start();
    ssap_master_i.xfer(8'h99, 1, q, ak); chk("rd ack", ak, 0);
    ssap_master_i.xfer(8'hff, 0, q, ak); chk("msb", q, 8'ha5);
    ssap_master_i.xfer(8'hff, 1, q, ak); chk("lsb", q, 8'h5a);
    chk("nack free", sda_oe_n, 1);
    ssap_master_i.stop();
    chk("ptr kept", ptr, 8'h05);
    ssap_master_i.start();
    ssap_master_i.xfer(8'h90, 1, q, ak); chk("foreign", ak, 1);
    ssap_master_i.stop();
    ssap_master_i.start();
    ssap_master_i.xfer(8'h0b, 1, q, ak); chk("hs nack", ak, 1);
    chk("hs on", hs_mode, 1);
    ssap_master_i.start();
    chk("hs kept", hs_mode, 1);
    ssap_master_i.stop();
    repeat (6) @(posedge pclk);
    chk("hs off", hs_mode, 0);
    $display("test bus done");
  endtask
  task automatic t_timeout();
    ssap_master_i.start();
    ssap_master_i.xfer(8'h98, 1, q, ak); chk("to ack", ak, 0);
    repeat (500) @(posedge pclk);
    apb(0, REG_STATE, 0); chk("to idle", rd[9], 0);
    chk("to free", sda_oe_n, 1);
    ssap_master_i.xfer(8'h05, 1, q, ak); chk("to ignore", ak, 1);
    ssap_master_i.stop();
    $display("test timeout done");
  endtask
  task automatic rd1(input logic [7:0] a);
    ssap_master_i.start();
    ssap_master_i.xfer(a, 1, q, ak); chk("rd addr ack", ak, 0);
    ssap_master_i.xfer(8'hff, 1, q, ak);
    ssap_master_i.stop();
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_filter();
    ssap_master_i.start();
    ssap_master_i.xfer(8'h00, 1, q, ak); chk("gc ack", ak, 0);
    ssap_master_i.xfer(8'h06, 1, q, ak);
    ssap_master_i.stop();
    chk("gc pins", {ot_n, st_n}, 2'b11);
    apb(0, REG_CFG, 0); chk("gc cfg", rd, 32'h00);
    apb(1, REG_CONS, 32'h81);
    conv(8'h60, 8'h20); chk("one fault", st_n, 1);
    conv(8'h60, 8'h20); chk("two faults", st_n, 0);
    rd1(ARA_BYTE);
    chk("ara addr", q, 8'h99);
    chk("ara free", st_n, 1);
    ro <= 1;
    repeat (3) @(posedge pclk);
    chk("open", st_n, 0);
    ro <= 0;
    conv(8'h30, 8'h20);
    rd1(8'h99); chk("kept", st_n, 0);
    apb(1, REG_STATUS, 32'h1f);
    rd1(8'h99); chk("cleared", st_n, 1);
    apb(1, REG_CFG, 32'h20);
    conv(8'h60, 8'h20); chk("th2 on", st_n, 0);
    conv(8'h4a, 8'h20); chk("th2 off", st_n, 1);
    $display("test filter done");
  endtask
  task automatic t_alarm();
    conv(8'h60, 8'h20);
    chk("ot on", ot_n, 0);
    chk("alert", st_n, 0);
    conv(8'h4c, 8'h20); chk("ot hyst", ot_n, 0);
    conv(8'h4a, 8'h20); chk("ot free", ot_n, 1);
    conv(8'h60, 8'h20);
    apb(1, REG_CFG, 32'h80);
    repeat (4) @(posedge pclk);
    chk("masked", st_n, 1);
    chk("ot unmasked", ot_n, 0);
    $display("test alarm done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_bus();
    t_timeout();
    t_alarm();
    t_filter();
    report_and_stop();
  end
  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
